// *** ctsf_pkg.sv ***
// Package for the CAN transmit select and acceptance control block.
// Assumes a 32-bit classic Wishbone slave with byte addresses.
package ctsf_pkg;
   // Register byte offsets
   localparam logic [7:0] OFS_TX_EMPTY = 8'h00;
   localparam logic [7:0] OFS_ABORT_REQ = 8'h04;
   localparam logic [7:0] OFS_ABORT_ACK = 8'h08;
   localparam logic [7:0] OFS_TX_SELECT = 8'h0c;
   localparam logic [7:0] OFS_ACCEPT_CTRL = 8'h10;
   localparam logic [7:0] OFS_TEST = 8'h14;
   localparam logic [7:0] OFS_CONTROL = 8'h18;
   localparam logic [7:0] OFS_IRQ_STATUS = 8'h1c;
   localparam logic [7:0] OFS_IRQ_CLEAR = 8'h20;
   localparam logic [7:0] OFS_IRQ_ENABLE = 8'h24;
   // Field positions
   localparam int ACC_MODE_LSB = 4;
   localparam int ACC_HIT_LSB = 0;
   localparam int CTRL_INIT_REQ_BIT = 0;
   localparam int CTRL_INIT_ACK_BIT = 1;
   // Interrupt status bits
   localparam int IRQ_ABORT_BIT = 0;
   localparam int IRQ_SENT_BIT = 1;
   localparam int IRQ_RX_BIT = 2;
   // Reset values
   localparam logic [2:0] TX_RST = 3'h0;
   localparam logic [1:0] MODE_RST = 2'h0;
   localparam logic [2:0] HIT_RST = 3'h0;
   localparam logic [2:0] IRQ_RST = 3'h0;

   // Acceptance filter organisation
   typedef enum logic [1:0] {
      MODE_TWO_32 = 2'h0,
      MODE_FOUR_16 = 2'h1,
      MODE_EIGHT_8 = 2'h2,
      MODE_CLOSED = 2'h3
   } ctsf_mode_t;

   // Events from the transmit engine, one bit per buffer
   typedef struct packed {
      logic [2:0] sent;
      logic [2:0] aborted;
   } ctsf_tx_evt_t;

   // Receive engine offering a new foreground message
   typedef struct packed {
      logic valid;
      logic [2:0] hit;
   } ctsf_rx_evt_t;
endpackage : ctsf_pkg

// *** ctsf_ctrl.sv ***
// CAN transmit buffer selection, abort acknowledge and acceptance control.
// Assumes a Wishbone master, and engines that only raise events per buffer.
// Operation
// - Abort drop sets buffer abort acknowledge flag
// - Clearing empty flag clears abort acknowledge
// - Abort acknowledge read-only, reset in init
// - Lowest set select bit picks window buffer
// - Select reads back lowest set bit only
// - Window blocked while selected buffer is scheduled
// - No buffer selected means no window access
// - Select writable outside init, reset in init
// - Mode field sets filter organisation
// - Closed filter accepts no message
// - Hit field reports matching filter number
// - Hit updates when foreground buffer reloads
// - Accept control writable only in init
// - Test register reads zero, ignores writes
// - Empty flag set on send or abort
// - Empty flag set clears abort request
//
// Decided for this implementation: register access over Wishbone and the address map.
`timescale 1ns/1ps
module ctsf_ctrl (
   // Clock, enable, reset
   input wire logic clk,
   input wire logic clkEn,
   input wire logic srst,
   // Wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // Transmit engine
   input wire ctsf_pkg::ctsf_tx_evt_t txEvt,
   output logic [2:0] txEmpty,
   output logic [2:0] abortReq,
   // Receive engine
   input wire ctsf_pkg::ctsf_rx_evt_t rxEvt,
   output logic rxAccept,
   output logic [1:0] acceptMode,
   // Transmit buffer window
   input wire logic winReq,
   output logic winGrant,
   output logic [1:0] winBufIdx,
   // Interrupt
   output logic irq
);

   logic [2:0] txEmpty_q, txEmpty_d;
   logic [2:0] abortReq_q, abortReq_d;
   logic [2:0] abortAck_q, abortAck_d;
   logic [2:0] txSel_q, txSel_d;
   logic [1:0] mode_q, mode_d;
   logic [2:0] hit_q, hit_d;
   logic initReq_q, initReq_d;
   logic initAck_q, initAck_d;
   logic [2:0] irqStat_q, irqStat_d;
   logic [2:0] irqEn_q, irqEn_d;
   logic ack_q;
   logic [31:0] rdat_q, rdat_d;

   // Bus decode
   wire logic busReq = cyc_i && stb_i && !ack_q;
   wire logic busAck = cyc_i && stb_i && ack_q; // Writes land when the master sees ack
   wire logic wrLow = busAck && we_i && sel_i[0];
   wire logic inInit = initReq_q && initAck_q;
   wire logic wrEmpty = wrLow && adr_i == ctsf_pkg::OFS_TX_EMPTY;
   wire logic wrAbort = wrLow && adr_i == ctsf_pkg::OFS_ABORT_REQ;
   wire logic wrSel = wrLow && adr_i == ctsf_pkg::OFS_TX_SELECT;
   wire logic wrAcc = wrLow && adr_i == ctsf_pkg::OFS_ACCEPT_CTRL;
   wire logic wrCtrl = wrLow && adr_i == ctsf_pkg::OFS_CONTROL;
   wire logic wrIClr = wrLow && adr_i == ctsf_pkg::OFS_IRQ_CLEAR;
   wire logic wrIEn = wrLow && adr_i == ctsf_pkg::OFS_IRQ_ENABLE;

   // Lowest set select bit
   wire logic [2:0] selLow = txSel_q & (~txSel_q + 3'h1);
   wire logic [2:0] wrLowBit = dat_i[2:0] & (~dat_i[2:0] + 3'h1);

   // Empty flags cleared by writing one, set by engine events
   wire logic [2:0] swClr = wrEmpty && !inInit ? dat_i[2:0] : 3'h0;
   wire logic [2:0] hwSet = txEvt.sent | txEvt.aborted;
   wire logic [2:0] abortEvt = txEvt.aborted & abortReq_q;

   // Transmit flag next state
   always_comb
   begin
      txEmpty_d = inInit ? 3'h7 : (txEmpty_q & ~swClr) | hwSet;
      abortReq_d = (abortReq_q | (wrAbort ? dat_i[2:0] & ~txEmpty_q : 3'h0))
         & ~hwSet;
      if (inInit)
         abortReq_d = ctsf_pkg::TX_RST;
      abortAck_d = (abortAck_q & ~swClr) | abortEvt;
      if (inInit)
         abortAck_d = ctsf_pkg::TX_RST;
   end

   // Selection, acceptance control and init handshake
   always_comb
   begin
      txSel_d = txSel_q;
      if (inInit)
         txSel_d = ctsf_pkg::TX_RST;
      else if (wrSel)
         txSel_d = wrLowBit;
      mode_d = mode_q;
      if (wrAcc && inInit)
         mode_d = dat_i[ctsf_pkg::ACC_MODE_LSB +: 2];
      hit_d = hit_q;
      if (rxAccept)
         hit_d = rxEvt.hit;
      initReq_d = wrCtrl ? dat_i[ctsf_pkg::CTRL_INIT_REQ_BIT] : initReq_q;
      initAck_d = initReq_q;
   end

   // Closed filter blocks reloads
   assign rxAccept = rxEvt.valid && mode_q != ctsf_pkg::MODE_CLOSED;

   // Window access gating
   assign winGrant = winReq && |(selLow & txEmpty_q);
   assign winBufIdx = selLow[0] ? 2'h0 : (selLow[1] ? 2'h1 : 2'h2);

   // Sticky interrupt status; set wins over clear
   always_comb
   begin
      irqStat_d = irqStat_q & ~(wrIClr ? dat_i[2:0] : 3'h0);
      irqStat_d[ctsf_pkg::IRQ_ABORT_BIT] = irqStat_d[ctsf_pkg::IRQ_ABORT_BIT] | |abortEvt;
      irqStat_d[ctsf_pkg::IRQ_SENT_BIT] = irqStat_d[ctsf_pkg::IRQ_SENT_BIT] | |txEvt.sent;
      irqStat_d[ctsf_pkg::IRQ_RX_BIT] = irqStat_d[ctsf_pkg::IRQ_RX_BIT] | rxAccept;
      irqEn_d = wrIEn ? dat_i[2:0] : irqEn_q;
   end

   // Read mux
   always_comb
   begin
      rdat_d = 32'h0;
      case (adr_i)
         ctsf_pkg::OFS_TX_EMPTY: rdat_d[2:0] = txEmpty_q;
         ctsf_pkg::OFS_ABORT_REQ: rdat_d[2:0] = abortReq_q;
         ctsf_pkg::OFS_ABORT_ACK: rdat_d[2:0] = abortAck_q;
         ctsf_pkg::OFS_TX_SELECT: rdat_d[2:0] = selLow;
         ctsf_pkg::OFS_ACCEPT_CTRL:
         begin
            rdat_d[ctsf_pkg::ACC_MODE_LSB +: 2] = mode_q;
            rdat_d[ctsf_pkg::ACC_HIT_LSB +: 3] = hit_q;
         end
         ctsf_pkg::OFS_TEST: rdat_d = 32'h0;
         ctsf_pkg::OFS_CONTROL:
         begin
            rdat_d[ctsf_pkg::CTRL_INIT_REQ_BIT] = initReq_q;
            rdat_d[ctsf_pkg::CTRL_INIT_ACK_BIT] = initAck_q;
         end
         ctsf_pkg::OFS_IRQ_STATUS: rdat_d[2:0] = irqStat_q;
         ctsf_pkg::OFS_IRQ_ENABLE: rdat_d[2:0] = irqEn_q;
         default: rdat_d = 32'h0;
      endcase
   end

   // State registers
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         txEmpty_q <= 3'h7;
         abortReq_q <= ctsf_pkg::TX_RST;
         abortAck_q <= ctsf_pkg::TX_RST;
         txSel_q <= ctsf_pkg::TX_RST;
         mode_q <= ctsf_pkg::MODE_RST;
         hit_q <= ctsf_pkg::HIT_RST;
         initReq_q <= 1'b0;
         initAck_q <= 1'b0;
         irqStat_q <= ctsf_pkg::IRQ_RST;
         irqEn_q <= ctsf_pkg::IRQ_RST;
         ack_q <= 1'b0;
         rdat_q <= 32'h0;
      end
      else if (clkEn)
      begin
         txEmpty_q <= txEmpty_d;
         abortReq_q <= abortReq_d;
         abortAck_q <= abortAck_d;
         txSel_q <= txSel_d;
         mode_q <= mode_d;
         hit_q <= hit_d;
         initReq_q <= initReq_d;
         initAck_q <= initAck_d;
         irqStat_q <= irqStat_d;
         irqEn_q <= irqEn_d;
         ack_q <= busReq;
         rdat_q <= rdat_d;
      end
   end

   // Outputs
   assign ack_o = ack_q;
   assign dat_o = rdat_q;
   assign txEmpty = txEmpty_q;
   assign abortReq = abortReq_q;
   assign acceptMode = mode_q;
   assign irq = |(irqStat_q & irqEn_q);

   // Abort event with pending request sets acknowledge next cycle
   property p_abort_ack;
      @(posedge clk) disable iff (srst)
      (clkEn && !inInit && |abortEvt) |=> |(abortAck_q & $past(abortEvt));
   endproperty
   a_abort_ack: assert property (p_abort_ack) else $error("abort ack not set");

   // Clearing empty flag drops acknowledge
   property p_ack_clear;
      @(posedge clk) disable iff (srst)
      (clkEn && swClr[0] && !abortEvt[0]) |=> !abortAck_q[0];
   endproperty
   a_ack_clear: assert property (p_ack_clear) else $error("ack survived clear");

   // Init mode holds acknowledge and select at reset value
   property p_init_hold;
      @(posedge clk) disable iff (srst)
      (clkEn && inInit) |=> (abortAck_q == 3'h0 && txSel_q == 3'h0);
   endproperty
   a_init_hold: assert property (p_init_hold) else $error("init did not clear");

   // Select readback is one-hot or zero
   property p_sel_onehot;
      @(posedge clk) disable iff (srst)
      $onehot0(selLow) && (selLow == 3'h0 || (selLow & txSel_q) != 3'h0);
   endproperty
   a_sel_onehot: assert property (p_sel_onehot) else $error("select not lowest");

   // Grant only to an empty selected buffer
   property p_window;
      @(posedge clk) disable iff (srst)
      winGrant |-> (txSel_q != 3'h0 && txEmpty_q[winBufIdx]);
   endproperty
   a_window: assert property (p_window) else $error("window granted wrongly");

   // Closed filter never reloads hit
   property p_closed;
      @(posedge clk) disable iff (srst)
      (mode_q == ctsf_pkg::MODE_CLOSED) |-> !rxAccept;
   endproperty
   a_closed: assert property (p_closed) else $error("closed filter accepted");

   // Accepted hit captured
   property p_hit;
      @(posedge clk) disable iff (srst)
      (clkEn && rxAccept) |=> hit_q == $past(rxEvt.hit);
   endproperty
   a_hit: assert property (p_hit) else $error("hit not updated");

   // Mode changes only in init
   property p_mode_lock;
      @(posedge clk) disable iff (srst)
      !inInit |=> $stable(mode_q);
   endproperty
   a_mode_lock: assert property (p_mode_lock) else $error("mode changed outside init");

   // Empty set clears abort request
   property p_req_clear;
      @(posedge clk) disable iff (srst)
      (clkEn && hwSet[1]) |=> (txEmpty_q[1] && !abortReq_q[1]);
   endproperty
   a_req_clear: assert property (p_req_clear) else $error("request not cleared");

   // Software cannot drop a pending abort request
   property p_req_keep;
      @(posedge clk) disable iff (srst)
      (clkEn && !inInit && abortReq_q[0] && !hwSet[0]) |=> abortReq_q[0];
   endproperty
   a_req_keep: assert property (p_req_keep) else $error("abort request lost");

   // Sent buffer reports empty
   property p_empty_sent;
      @(posedge clk) disable iff (srst)
      (clkEn && |txEvt.sent) |=> (txEmpty_q & $past(txEvt.sent)) == $past(txEvt.sent);
   endproperty
   a_empty_sent: assert property (p_empty_sent) else $error("sent buffer not empty");

   // Acknowledge flag sticks until its empty flag is cleared
   property p_ack_keep;
      @(posedge clk) disable iff (srst)
      (clkEn && !inInit && abortAck_q[1] && !swClr[1]) |=> abortAck_q[1];
   endproperty
   a_ack_keep: assert property (p_ack_keep) else $error("ack dropped early");

   // Writes to the acknowledge register change nothing
   property p_ack_ro;
      @(posedge clk) disable iff (srst)
      (clkEn && !inInit && wrLow && adr_i == ctsf_pkg::OFS_ABORT_ACK && abortEvt == 3'h0)
         |=> $stable(abortAck_q);
   endproperty
   a_ack_ro: assert property (p_ack_ro) else $error("ack register written");

   // Select stores the lowest written bit
   property p_sel_write;
      @(posedge clk) disable iff (srst)
      (clkEn && !inInit && wrSel) |=> txSel_q == $past(wrLowBit);
   endproperty
   a_sel_write: assert property (p_sel_write) else $error("select write wrong");

   // Select holds without a write
   property p_sel_hold;
      @(posedge clk) disable iff (srst)
      (clkEn && !inInit && !wrSel) |=> $stable(txSel_q);
   endproperty
   a_sel_hold: assert property (p_sel_hold) else $error("select changed");

   // Buffer 0 selected and empty opens the window on it
   property p_win_open;
      @(posedge clk) disable iff (srst)
      (winReq && txSel_q[0] && txEmpty_q[0]) |-> (winGrant && winBufIdx == 2'h0);
   endproperty
   a_win_open: assert property (p_win_open) else $error("window not opened");

   // Nothing selected, no window
   property p_win_none;
      @(posedge clk) disable iff (srst)
      (txSel_q == 3'h0) |-> !winGrant;
   endproperty
   a_win_none: assert property (p_win_none) else $error("window without select");

   // Mode write in init lands
   property p_mode_write;
      @(posedge clk) disable iff (srst)
      (clkEn && inInit && wrAcc) |=> mode_q == $past(dat_i[ctsf_pkg::ACC_MODE_LSB +: 2]);
   endproperty
   a_mode_write: assert property (p_mode_write) else $error("mode write lost");

   // Hit moves only with a reload
   property p_hit_hold;
      @(posedge clk) disable iff (srst)
      (clkEn && !rxAccept) |=> $stable(hit_q);
   endproperty
   a_hit_hold: assert property (p_hit_hold) else $error("hit changed");

   // Accepted message raises receive status
   property p_irq_rx;
      @(posedge clk) disable iff (srst)
      (clkEn && rxAccept) |=> irqStat_q[ctsf_pkg::IRQ_RX_BIT];
   endproperty
   a_irq_rx: assert property (p_irq_rx) else $error("rx status not set");

   // Abort event raises abort status
   property p_irq_abort;
      @(posedge clk) disable iff (srst)
      (clkEn && |abortEvt) |=> irqStat_q[ctsf_pkg::IRQ_ABORT_BIT];
   endproperty
   a_irq_abort: assert property (p_irq_abort) else $error("abort status not set");

   // Taken request acknowledged next cycle
   property p_bus_ack;
      @(posedge clk) disable iff (srst)
      (clkEn && busReq) |=> ack_q;
   endproperty
   a_bus_ack: assert property (p_bus_ack) else $error("request not acknowledged");

   // Test register reads zero
   property p_test_read;
      @(posedge clk) disable iff (srst)
      (clkEn && busReq && adr_i == ctsf_pkg::OFS_TEST) |=> dat_o == 32'h0;
   endproperty
   a_test_read: assert property (p_test_read) else $error("test register not zero");

   // Select reads back its lowest set bit
   property p_sel_read;
      @(posedge clk) disable iff (srst)
      (clkEn && busReq && adr_i == ctsf_pkg::OFS_TX_SELECT) |=> dat_o == {29'h0, $past(selLow)};
   endproperty
   a_sel_read: assert property (p_sel_read) else $error("select readback wrong");

   // Acknowledge register reads its flags
   property p_ack_read;
      @(posedge clk) disable iff (srst)
      (clkEn && busReq && adr_i == ctsf_pkg::OFS_ABORT_ACK) |=> dat_o == {29'h0, $past(abortAck_q)};
   endproperty
   a_ack_read: assert property (p_ack_read) else $error("ack readback wrong");

   // Reset clears select, acknowledge and acceptance fields
   property p_reset_vals;
      @(posedge clk)
      srst |=> (txSel_q == 3'h0 && abortAck_q == 3'h0 && mode_q == 2'h0 && hit_q == 3'h0);
   endproperty
   a_reset_vals: assert property (p_reset_vals) else $error("reset values wrong");

endmodule : ctsf_ctrl

// *** ctsf_engine_model.sv ***
// Behavioural transmit and receive engine facing the control block.
// Assumes tasks are called from the testbench just after a rising edge.
`timescale 1ns/1ps
module ctsf_engine_model (
   // Clock
   input wire logic clk,
   // Engine events
   output ctsf_pkg::ctsf_tx_evt_t txEvt,
   output ctsf_pkg::ctsf_rx_evt_t rxEvt,
   // Window request
   output logic winReq,
   // Acceptance answer
   input wire logic rxAccept
);
   // Quiet engine at time zero, window requested until setWin drops it
   initial
   begin
      txEvt = '0;
      rxEvt = '0;
      winReq = 1'b1;
   end

   // One-cycle sent or aborted pulse on one buffer
   task automatic txPulse(input logic isAbort, input int idx);
      @(posedge clk);
      if (isAbort)
         txEvt.aborted[idx] <= 1'b1;
      else
         txEvt.sent[idx] <= 1'b1;
      @(posedge clk);
      txEvt <= '0;
      #1;
   endtask : txPulse

   // Offer a message; acceptance is looked at in the offer cycle
   task automatic offerRx(input logic [2:0] hit, output logic acc);
      @(posedge clk);
      rxEvt <= {1'b1, hit};
      #1 acc = rxAccept;
      @(posedge clk);
      rxEvt <= {1'b0, ~hit};
      #1;
   endtask : offerRx

   // Drop or raise the window request
   task automatic setWin(input logic on);
      @(posedge clk);
      winReq <= on;
      #1;
   endtask : setWin
endmodule : ctsf_engine_model

// *** ctsf_ctrl_tb.sv ***
// Self-checking bench: Wishbone register tasks plus engine model events.
// Assumes one 10 MHz clock and the offsets of the block package.
`timescale 1ns/1ps
module ctsf_ctrl_tb;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic clkEn = 1'b1;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] dat = 32'h0, datO;
   logic ack, rxAccept, winGrant, irq, acc;
   logic [2:0] txEmpty, abortReq;
   logic [1:0] acceptMode, winBufIdx;
   logic winReq;
   ctsf_pkg::ctsf_tx_evt_t txEvt;
   ctsf_pkg::ctsf_rx_evt_t rxEvt;
   int n_fail = 0, n_compared = 0;

   ctsf_ctrl u_ctsf_ctrl (.clk(clk), .clkEn(clkEn), .srst(srst), .cyc_i(cyc), .stb_i(stb),
      .we_i(we), .adr_i(adr), .sel_i(4'h1), .dat_i(dat), .dat_o(datO), .ack_o(ack),
      .txEvt(txEvt), .txEmpty(txEmpty), .abortReq(abortReq), .rxEvt(rxEvt),
      .rxAccept(rxAccept), .acceptMode(acceptMode), .winReq(winReq), .winGrant(winGrant),
      .winBufIdx(winBufIdx), .irq(irq));
   ctsf_engine_model u_ctsf_engine_model (.clk(clk), .txEvt(txEvt), .rxEvt(rxEvt),
      .winReq(winReq), .rxAccept(rxAccept));

   // 100 ns clock
   initial
   begin
      forever #50 clk = ~clk;
   end

   // Verdict and stop
   task automatic end_sim;
      $display("Compared %0d, failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : end_sim

   // Value compare
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         n_fail++;
         $display("BAD at %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // Classic single cycle; released at the edge that samples ack high
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q);
      int n;
      n = 0;
      q = 32'h0;
      @(posedge clk);
      {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
      @(posedge clk);
      while (ack !== 1'b1 && n < 20)
      begin
         @(posedge clk);
         n++;
      end
      if (n >= 20)
         chk(32'hdead, 32'h0);
      q = datO;
      {cyc, stb, we, dat} <= {3'b000, ~d};
      #1;
   endtask : wb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      wb(1'b1, a, d, q);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] q;
      wb(1'b0, a, 32'h0, q);
      chk(q, exp);
   endtask : rd

   // Watchdog, several times the few hundred cycles the tests need
   initial
   begin
      #300000;
      n_fail++;
      end_sim();
   end

   // Test sequence
   initial
   begin
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      #1;
      rd(ctsf_pkg::OFS_TX_EMPTY, 32'h7);
      rd(ctsf_pkg::OFS_ABORT_ACK, 32'h0);
      rd(ctsf_pkg::OFS_TX_SELECT, 32'h0);
      rd(ctsf_pkg::OFS_ACCEPT_CTRL, 32'h0);
      wr(ctsf_pkg::OFS_TEST, 32'hff);
      rd(ctsf_pkg::OFS_TEST, 32'h0);
      rd(8'h30, 32'h0);
      // Next free buffer by copying empty flags into select
      wr(ctsf_pkg::OFS_TX_EMPTY, 32'h1);
      rd(ctsf_pkg::OFS_TX_EMPTY, 32'h6);
      wr(ctsf_pkg::OFS_TX_SELECT, 32'h6);
      rd(ctsf_pkg::OFS_TX_SELECT, 32'h2);
      chk({winGrant, winBufIdx}, 32'h5);
      u_ctsf_engine_model.setWin(1'b0);
      chk(winGrant, 32'h0);
      u_ctsf_engine_model.setWin(1'b1);
      chk(winGrant, 32'h1);
      wr(ctsf_pkg::OFS_TX_SELECT, 32'h0);
      chk(winGrant, 32'h0);
      wr(ctsf_pkg::OFS_TX_SELECT, 32'h7);
      rd(ctsf_pkg::OFS_TX_SELECT, 32'h1);
      chk({winGrant, winBufIdx}, 32'h0);
      // Abort of scheduled buffer 0 with interrupt
      wr(ctsf_pkg::OFS_ABORT_REQ, 32'h1);
      chk(abortReq, 32'h1);
      wr(ctsf_pkg::OFS_IRQ_ENABLE, 32'h1);
      u_ctsf_engine_model.txPulse(1'b1, 0);
      rd(ctsf_pkg::OFS_ABORT_ACK, 32'h1);
      chk({abortReq, txEmpty, irq, winGrant}, 32'h1f);
      wr(ctsf_pkg::OFS_ABORT_ACK, 32'h0);
      rd(ctsf_pkg::OFS_ABORT_ACK, 32'h1);
      wr(ctsf_pkg::OFS_IRQ_ENABLE, 32'h0);
      chk(irq, 32'h0);
      wr(ctsf_pkg::OFS_IRQ_ENABLE, 32'h1);
      chk(irq, 32'h1);
      wr(ctsf_pkg::OFS_IRQ_CLEAR, 32'h1);
      chk(irq, 32'h0);
      rd(ctsf_pkg::OFS_IRQ_STATUS, 32'h0);
      wr(ctsf_pkg::OFS_TX_EMPTY, 32'h3);
      rd(ctsf_pkg::OFS_ABORT_ACK, 32'h0);
      u_ctsf_engine_model.txPulse(1'b0, 1);
      rd(ctsf_pkg::OFS_TX_EMPTY, 32'h6);
      // Initialization mode effects
      wr(ctsf_pkg::OFS_ABORT_REQ, 32'h1);
      u_ctsf_engine_model.txPulse(1'b1, 0);
      wr(ctsf_pkg::OFS_TX_SELECT, 32'h4);
      rd(ctsf_pkg::OFS_TX_SELECT, 32'h4);
      wr(ctsf_pkg::OFS_ACCEPT_CTRL, 32'h10);
      rd(ctsf_pkg::OFS_ACCEPT_CTRL, 32'h0);
      wr(ctsf_pkg::OFS_CONTROL, 32'h1);
      rd(ctsf_pkg::OFS_CONTROL, 32'h3);
      rd(ctsf_pkg::OFS_ABORT_ACK, 32'h0);
      wr(ctsf_pkg::OFS_TX_SELECT, 32'h2);
      rd(ctsf_pkg::OFS_TX_SELECT, 32'h0);
      for (int m = 0; m < 4; m++)
      begin
         wr(ctsf_pkg::OFS_ACCEPT_CTRL, {26'h0, m[1:0], 4'h7});
         rd(ctsf_pkg::OFS_ACCEPT_CTRL, {26'h0, m[1:0], 4'h0});
         chk(acceptMode, m[1:0]);
      end
      wr(ctsf_pkg::OFS_CONTROL, 32'h0);
      rd(ctsf_pkg::OFS_CONTROL, 32'h0);
      // Closed filter, then four 16-bit filters with hits
      u_ctsf_engine_model.offerRx(3'h5, acc);
      chk(acc, 32'h0);
      rd(ctsf_pkg::OFS_ACCEPT_CTRL, 32'h30);
      wr(ctsf_pkg::OFS_CONTROL, 32'h1);
      wr(ctsf_pkg::OFS_ACCEPT_CTRL, 32'h10);
      wr(ctsf_pkg::OFS_CONTROL, 32'h0);
      rd(ctsf_pkg::OFS_CONTROL, 32'h0);
      u_ctsf_engine_model.offerRx(3'h5, acc);
      chk(acc, 32'h1);
      rd(ctsf_pkg::OFS_ACCEPT_CTRL, 32'h15);
      u_ctsf_engine_model.offerRx(3'h7, acc);
      rd(ctsf_pkg::OFS_ACCEPT_CTRL, 32'h17);
      // Low clock enable freezes state: an event then is lost
      wr(ctsf_pkg::OFS_TX_EMPTY, 32'h4);
      @(posedge clk);
      clkEn <= 1'b0;
      u_ctsf_engine_model.txPulse(1'b0, 2);
      clkEn <= 1'b1;
      rd(ctsf_pkg::OFS_TX_EMPTY, 32'h3);
      u_ctsf_engine_model.txPulse(1'b0, 2);
      rd(ctsf_pkg::OFS_TX_EMPTY, 32'h7);
      // Reset in mid-run returns fields to zero
      @(posedge clk);
      srst <= 1'b1;
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      rd(ctsf_pkg::OFS_ACCEPT_CTRL, 32'h0);
      rd(ctsf_pkg::OFS_TX_SELECT, 32'h0);
      end_sim();
   end
endmodule : ctsf_ctrl_tb
